//--- src/cms_device.sv
// configured device end: power-on delay, command mode, loading, user mode
module cms_device #(
  parameter int unsigned POR_LONG  = cms_pkg::POR_LONG_CYC,
  parameter int unsigned POR_SHORT = cms_pkg::POR_SHORT_CYC
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  // link to the configuration host
  cms_link_if.dev                          link,
  // board straps
  input  wire logic                        power_on_delay_select,
  input  wire logic                        io_pullup_off,
  // test port instruction
  input  wire logic [cms_pkg::IR_W-1:0]    tap_ir,
  input  wire logic                        tap_ir_update,
  // user side
  output logic                             io_enable_q,
  output logic                             weak_pullup_en_q,
  output logic                             command_mode_q,
  output logic                             user_mode_q,
  output logic                             user_reg_reset_q,
  input  wire logic [cms_pkg::IDX_W-1:0]   cfg_rd_idx,
  output logic [cms_pkg::DATA_W-1:0]       cfg_rd_data_q
);
  localparam int DW = cms_pkg::DATA_W;
  localparam int LW = $clog2(cms_pkg::FIFO_DEPTH) + 1;

  cms_pkg::cms_state_t   state_q;
  cms_pkg::cms_scheme_t  scheme_q;
  logic                  compressed_q, encrypted_q;
  logic [cms_pkg::POR_CNT_W-1:0] por_cnt_q;
  logic                  por_sel_q, pull_off_q;
  logic [3:0]            init_cnt_q;
  logic                  trig_q;
  logic                  hold_req;
  // intake
  logic [DW-1:0]         sr_q;
  logic [2:0]            bit_cnt_q;
  logic                  push_q;
  logic [DW-1:0]         push_data_q;
  logic [DW-1:0]         ks_q;
  logic                  ready_q;
  logic                  beat;
  // fifo drain and expansion
  logic                  f_in_ready, f_out_valid, f_out_ready;
  logic [DW-1:0]         f_out_data;
  logic [LW-1:0]         f_level;
  logic                  have_count_q;
  logic [DW-1:0]         rep_q, val_q;
  logic [cms_pkg::IDX_W-1:0] wr_idx_q;
  logic [DW-1:0]         cfg_mem_q [cms_pkg::CFG_BYTES];
  logic                  mem_full, emitting, mem_we;
  logic [DW-1:0]         mem_wd;
  logic                  chain_out_n_q, status_n_q, conf_done_q;

  assign link.ready              = ready_q;
  assign link.chain_enable_out_n = chain_out_n_q;
  assign link.status_n           = status_n_q;
  assign link.conf_done          = conf_done_q;

  // pin low or test instruction forces the hold state
  assign hold_req = !link.reconfig_request_n || trig_q;
  assign mem_full = (wr_idx_q == cms_pkg::IDX_W'(cms_pkg::CFG_BYTES));
  assign emitting = (rep_q != '0);

  // test instruction behaves as a one-cycle low pulse on the pin
  always_ff @(posedge core_clk) begin
    if (srst) trig_q <= 1'b0;
    else trig_q <= tap_ir_update && (tap_ir == cms_pkg::IR_RECONFIG);
  end

  // main sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= cms_pkg::st_por;
    end else begin
      case (state_q)
        cms_pkg::st_por: begin
          // limit chosen from the strap caught on the first cycle
          if (por_cnt_q != '0 &&
              por_cnt_q == cms_pkg::POR_CNT_W'((por_sel_q ? POR_SHORT : POR_LONG) - 1))
            state_q <= cms_pkg::st_wait;
        end
        cms_pkg::st_wait: begin
          if (hold_req) state_q <= cms_pkg::st_hold;
          else if (!link.chain_enable_in_n) state_q <= cms_pkg::st_load;
        end
        cms_pkg::st_load: begin
          if (hold_req) state_q <= cms_pkg::st_hold;
          else if (mem_full) state_q <= cms_pkg::st_init;
        end
        cms_pkg::st_init: begin
          if (hold_req) state_q <= cms_pkg::st_hold;
          else if (init_cnt_q == 4'(cms_pkg::INIT_CYC - 1)) state_q <= cms_pkg::st_user;
        end
        cms_pkg::st_user: begin
          if (hold_req) state_q <= cms_pkg::st_hold;
        end
        cms_pkg::st_hold: begin
          if (!hold_req) state_q <= cms_pkg::st_wait;
        end
        default: state_q <= cms_pkg::st_por;
      endcase
    end
  end

  // power-on counter; a reset restarts the whole delay
  always_ff @(posedge core_clk) begin
    if (srst) por_cnt_q <= '0;
    else if (state_q == cms_pkg::st_por) por_cnt_q <= por_cnt_q + 1'b1;
  end

  // pull-up strap sampled only outside user mode, delay strap only on the first power-on cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      por_sel_q  <= 1'b0;
      pull_off_q <= 1'b0;
    end else begin
      if (state_q == cms_pkg::st_por && por_cnt_q == '0)
        por_sel_q <= power_on_delay_select;
      if (state_q != cms_pkg::st_user)
        pull_off_q <= io_pullup_off;
    end
  end

  // initialization timer
  always_ff @(posedge core_clk) begin
    if (srst) init_cnt_q <= '0;
    else if (state_q == cms_pkg::st_init) init_cnt_q <= init_cnt_q + 1'b1;
    else init_cnt_q <= '0;
  end

  // scheme and stream options captured as loading starts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scheme_q     <= cms_pkg::passive_serial_scheme;
      compressed_q <= 1'b0;
      encrypted_q  <= 1'b0;
    end else if (state_q == cms_pkg::st_wait) begin
      scheme_q     <= link.scheme;
      compressed_q <= link.compressed;
      encrypted_q  <= link.encrypted;
    end
  end

  // async writes count only at the virtual address, synchronous need handshake
  always_comb begin
    if (state_q != cms_pkg::st_load) beat = 1'b0;
    else if (scheme_q == cms_pkg::passive_parallel_async_scheme)
      beat = !link.wr_n && (link.addr == cms_pkg::CFG_VIRT_ADDR);
    else beat = link.valid && ready_q;
  end

  // ready keeps three slots free for beats already in flight
  always_ff @(posedge core_clk) begin
    if (srst) ready_q <= 1'b0;
    else ready_q <= (state_q == cms_pkg::st_load) && !mem_full &&
                    (f_level <= LW'(cms_pkg::FIFO_DEPTH - 3)) && f_in_ready;
  end

  // serial bits gather lsb first; parallel bytes go straight on
  always_ff @(posedge core_clk) begin
    if (srst || state_q != cms_pkg::st_load) begin
      sr_q        <= '0;
      bit_cnt_q   <= '0;
      push_q      <= 1'b0;
      push_data_q <= '0;
      ks_q        <= cms_pkg::KEY_SEED;
    end else begin
      push_q <= 1'b0;
      if (beat) begin
        if (cms_pkg::cms_is_serial(scheme_q)) begin
          sr_q      <= {link.data[0], sr_q[DW-1:1]};
          bit_cnt_q <= bit_cnt_q + 1'b1;
          if (bit_cnt_q == 3'h7) begin
            push_q      <= 1'b1;
            push_data_q <= {link.data[0], sr_q[DW-1:1]} ^ (encrypted_q ? ks_q : '0);
            ks_q        <= cms_pkg::cms_ks_next(ks_q);
          end
        end else begin
          push_q      <= 1'b1;
          push_data_q <= link.data ^ (encrypted_q ? ks_q : '0);
          ks_q        <= cms_pkg::cms_ks_next(ks_q);
        end
      end
    end
  end

  // eight deep buffer; expansion stalls drain so the buffer can fill
  cms_fifo #(.W(DW), .D(cms_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .srst      (srst || state_q == cms_pkg::st_hold),
    .in_valid  (push_q),
    .in_ready  (f_in_ready),
    .in_data   (push_data_q),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // drain must not wait on a full buffer, or a full buffer never empties
  assign f_out_ready = (state_q == cms_pkg::st_load) && !emitting && !mem_full;

  // store path: plain bytes or run copies
  always_comb begin
    mem_we = 1'b0;
    mem_wd = f_out_data;
    if (state_q == cms_pkg::st_load && !mem_full) begin
      if (emitting) begin
        mem_we = 1'b1;
        mem_wd = val_q;
      end else if (!compressed_q) begin
        mem_we = f_out_valid && f_out_ready;
      end
    end
  end

  // run expander: count byte then value byte, copies without staging
  always_ff @(posedge core_clk) begin
    if (srst || state_q != cms_pkg::st_load) begin
      have_count_q <= 1'b0;
      rep_q        <= '0;
      val_q        <= '0;
    end else if (emitting) begin
      rep_q <= rep_q - 1'b1;
    end else if (compressed_q && f_out_valid && f_out_ready) begin
      if (!have_count_q) begin
        have_count_q <= 1'b1;
        val_q        <= f_out_data;
      end else begin
        have_count_q <= 1'b0;
        rep_q        <= val_q;
        val_q        <= f_out_data;
      end
    end
  end

  // configuration store; cleared index means a full reload is needed
  always_ff @(posedge core_clk) begin
    if (srst || state_q == cms_pkg::st_hold) wr_idx_q <= '0;
    else if (mem_we) wr_idx_q <= wr_idx_q + 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (mem_we) cfg_mem_q[wr_idx_q[cms_pkg::IDX_W-2:0]] <= mem_wd;
  end

  always_ff @(posedge core_clk) begin
    if (srst) cfg_rd_data_q <= '0;
    else cfg_rd_data_q <= cfg_mem_q[cfg_rd_idx[cms_pkg::IDX_W-2:0]];
  end

  // pin and mode outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      io_enable_q      <= 1'b0;
      weak_pullup_en_q <= 1'b0;
      command_mode_q   <= 1'b0;
      user_mode_q      <= 1'b0;
      user_reg_reset_q <= 1'b1;
      chain_out_n_q    <= 1'b1;
      status_n_q       <= 1'b0;
      conf_done_q      <= 1'b0;
    end else begin
      io_enable_q      <= (state_q == cms_pkg::st_user);
      weak_pullup_en_q <= (state_q != cms_pkg::st_user) && !pull_off_q;
      command_mode_q   <= (state_q == cms_pkg::st_load) ||
                          (state_q == cms_pkg::st_init);
      user_mode_q      <= (state_q == cms_pkg::st_user);
      user_reg_reset_q <= (state_q != cms_pkg::st_user);
      chain_out_n_q    <= !((state_q == cms_pkg::st_init) ||
                            (state_q == cms_pkg::st_user));
      status_n_q       <= !((state_q == cms_pkg::st_por) ||
                            (state_q == cms_pkg::st_hold));
      conf_done_q      <= (state_q == cms_pkg::st_init) || (state_q == cms_pkg::st_user);
    end
  end
endmodule : cms_device

//--- src/cms_fifo.sv
// flip-flop fifo with valid/ready on both sides
module cms_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  // occupancy
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0]   cnt_q;
  logic          push, pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign level     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage written at the write index
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cms_fifo

//--- src/cms_host.sv
// configuration host end: pulses reconfig and streams the bitstream
module cms_host (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // link to the device
  cms_link_if.host                   link,
  // user command
  input  wire logic                  start,
  input  wire cms_pkg::cms_scheme_t  scheme,
  input  wire logic                  compressed,
  input  wire logic                  encrypted,
  // byte source
  input  wire logic [7:0]            src_data,
  input  wire logic                  src_valid,
  output logic                       src_ready_q,
  // status
  output logic                       busy_q,
  output logic                       done_q
);
  typedef enum logic [2:0] {h_idle, h_pulse, h_wait, h_send, h_done} cms_hstate_t;
  cms_hstate_t          st_q;
  cms_pkg::cms_scheme_t scheme_q;
  logic                 comp_q, enc_q, req_n_q, ce_n_q, valid_q, wr_n_q, have_q;
  logic [7:0]           byte_q, data_q;
  logic [2:0]           bit_q, cnt_q;
  logic                 fire;

  assign link.reconfig_request_n = req_n_q;
  assign link.chain_enable_in_n  = ce_n_q;
  assign link.scheme             = scheme_q;
  assign link.compressed         = comp_q;
  assign link.encrypted          = enc_q;
  assign link.data               = data_q;
  assign link.valid              = valid_q;
  assign link.addr               = cms_pkg::CFG_VIRT_ADDR;
  assign link.wr_n               = wr_n_q;
  assign fire = valid_q && link.ready;

  // sequence: reconfig pulse, wait for status, send until done
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= h_idle; req_n_q <= 1'b1; ce_n_q <= 1'b1; cnt_q <= '0;
      scheme_q <= cms_pkg::passive_serial_scheme; comp_q <= 1'b0; enc_q <= 1'b0;
      busy_q <= 1'b0; done_q <= 1'b0;
    end else begin
      case (st_q)
        h_idle: if (start) begin
          st_q <= h_pulse; req_n_q <= 1'b0; cnt_q <= '0; busy_q <= 1'b1; done_q <= 1'b0;
          scheme_q <= scheme; comp_q <= compressed; enc_q <= encrypted;
        end
        h_pulse: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == 3'(cms_pkg::RECFG_LOW_CYC - 1)) begin
            req_n_q <= 1'b1; st_q <= h_wait;
          end
        end
        h_wait: if (link.status_n) begin
          ce_n_q <= 1'b0; st_q <= h_send;
        end
        h_send: if (link.conf_done) begin
          ce_n_q <= 1'b1; st_q <= h_done;
        end
        h_done: begin
          busy_q <= 1'b0; done_q <= 1'b1; st_q <= h_idle;
        end
        default: st_q <= h_idle;
      endcase
    end
  end

  // byte fetch and beat drive; serial sends lsb first
  always_ff @(posedge core_clk) begin
    if (srst || st_q != h_send || link.conf_done) begin
      have_q <= 1'b0; src_ready_q <= 1'b0; valid_q <= 1'b0; wr_n_q <= 1'b1;
      byte_q <= '0; data_q <= '0; bit_q <= '0;
    end else begin
      src_ready_q <= !have_q && !src_ready_q;
      if (src_ready_q && src_valid) begin
        have_q <= 1'b1; byte_q <= src_data; bit_q <= '0;
      end
      if (scheme_q == cms_pkg::passive_parallel_async_scheme) begin
        wr_n_q <= 1'b1;
        if (have_q && wr_n_q && link.ready) begin
          wr_n_q <= 1'b0; data_q <= byte_q; have_q <= 1'b0;
        end
      end else if (cms_pkg::cms_is_serial(scheme_q)) begin
        if (have_q && !valid_q) begin
          valid_q <= 1'b1; data_q <= {7'h00, byte_q[bit_q]};
        end else if (fire) begin
          valid_q <= 1'b0; bit_q <= bit_q + 1'b1;
          if (bit_q == 3'h7) have_q <= 1'b0;
        end
      end else begin
        if (have_q && !valid_q) begin
          valid_q <= 1'b1; data_q <= byte_q;
        end else if (fire) begin
          valid_q <= 1'b0; have_q <= 1'b0;
        end
      end
    end
  end
endmodule : cms_host

//--- src/cms_link_if.sv
// pins between the configuration host and the configured device
interface cms_link_if;
  logic                        reconfig_request_n;
  logic                        chain_enable_in_n;
  logic                        chain_enable_out_n;
  logic                        status_n;
  logic                        conf_done;
  cms_pkg::cms_scheme_t        scheme;
  logic                        compressed;
  logic                        encrypted;
  logic [cms_pkg::DATA_W-1:0]  data;
  logic                        valid;
  logic                        ready;
  logic [cms_pkg::ADDR_W-1:0]  addr;
  logic                        wr_n;

  modport dev (
    input  reconfig_request_n, chain_enable_in_n, scheme, compressed, encrypted,
    input  data, valid, addr, wr_n,
    output chain_enable_out_n, status_n, conf_done, ready
  );
  modport host (
    output reconfig_request_n, chain_enable_in_n, scheme, compressed, encrypted,
    output data, valid, addr, wr_n,
    input  chain_enable_out_n, status_n, conf_done, ready
  );
endinterface : cms_link_if

//--- src/cms_pkg.sv
// constants, types and decode helpers for the configuration mode sequencer
// Function
// - Power-on delay 100 ms low select, 12 ms high
// - User I/O tri-stated until configuration completes
// - After load, initialize registers then enable I/O
// - Load plus initialization form one command mode
// - Every power-up needs full load before user mode
// - Reconfig pin forces the hold state, then reload, resume
// - Pull-up control high disables weak pull-ups
// - Five schemes: parallel, active/passive serial, async, test
// - Host may send serial or parallel, sync or async
// - Async writes target one virtual memory address
// - Compressed stream expanded on the fly
// - Encrypted stream deciphered during loading
// - Test instruction triggers reconfig like pin pulse
// - Chain-enable out feeds next device's chain-enable in
package cms_pkg;
  // clock and power-on timing
  localparam int CLK_HZ       = 40_000_000;
  localparam int POR_LONG_MS  = 100;
  localparam int POR_SHORT_MS = 12;
  localparam int POR_LONG_CYC  = POR_LONG_MS * (CLK_HZ / 1000);
  localparam int POR_SHORT_CYC = POR_SHORT_MS * (CLK_HZ / 1000);
  localparam int POR_CNT_W     = 22;
  // initialization and reconfig pulse lengths, in cycles
  localparam int INIT_CYC      = 8;
  localparam int RECFG_LOW_CYC = 4;
  // data path geometry
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int CFG_BYTES  = 16;
  localparam int IDX_W      = 5;
  localparam logic [ADDR_W-1:0] CFG_VIRT_ADDR = 4'hA;
  // test port instruction
  localparam int IR_W = 10;
  localparam logic [IR_W-1:0] IR_RECONFIG = 10'h001;
  // keystream seed for the cipher stage
  localparam logic [DATA_W-1:0] KEY_SEED = 8'hA5;

  typedef enum logic [2:0] {
    fast_passive_parallel_scheme,
    active_serial_scheme,
    passive_serial_scheme,
    passive_parallel_async_scheme,
    test_port_scheme
  } cms_scheme_t;

  typedef enum logic [2:0] {
    st_por, st_wait, st_load, st_init, st_user, st_hold
  } cms_state_t;

  // one bit per beat for the serial and test port schemes
  function automatic logic cms_is_serial(input cms_scheme_t s);
    return (s == active_serial_scheme) || (s == passive_serial_scheme) ||
           (s == test_port_scheme);
  endfunction : cms_is_serial

  // next keystream byte
  function automatic logic [DATA_W-1:0] cms_ks_next(input logic [DATA_W-1:0] k);
    return {k[6:0], k[7] ^ k[5] ^ k[4] ^ k[3]};
  endfunction : cms_ks_next
endpackage : cms_pkg

//--- verif/cms_props.sv
// pin-level checks between configuration host and device
module cms_props (
  // clock and reset
  input logic                       core_clk,
  input logic                       srst,
  // host driven
  input logic                       reconfig_request_n,
  input logic [cms_pkg::DATA_W-1:0] data,
  input logic                       valid,
  input logic [cms_pkg::ADDR_W-1:0] addr,
  input logic                       wr_n,
  // device driven
  input logic                       chain_enable_out_n,
  input logic                       status_n,
  input logic                       conf_done,
  input logic                       ready
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // no data may be taken while status is held low
  AST_READY_GATED: assert property (ready |-> status_n)
    else $error("ready high while status low");
  AST_RECFG_ENTER: assert property ($fell(reconfig_request_n) && status_n |-> ##[1:3] (!status_n && !conf_done))
    else $error("reconfig did not drop status and done");
  AST_HOLD_LOW: assert property ((!reconfig_request_n)[*4] |-> !status_n && !conf_done && chain_enable_out_n)
    else $error("device not held by reconfig");
  AST_PULSE_LEN: assert property ($fell(reconfig_request_n) |-> (!reconfig_request_n)[*4] ##1 reconfig_request_n)
    else $error("reconfig pulse not four cycles");
  AST_DONE_CHAIN: assert property (conf_done |-> !chain_enable_out_n)
    else $error("chain out high while done");
  AST_DONE_RISE: assert property ($rose(conf_done) |-> status_n && reconfig_request_n)
    else $error("done rose while held");
  AST_ADDR_VIRT: assert property (!wr_n |-> addr == cms_pkg::CFG_VIRT_ADDR && $past(ready))
    else $error("write off the virtual address");
  AST_WR_PULSE: assert property (!wr_n |=> wr_n)
    else $error("write strobe longer than one cycle");
  AST_VALID_HOLD: assert property (valid && !ready |=> valid && $stable(data))
    else $error("beat dropped before taken");
endmodule : cms_props

//--- verif/tb_top.sv
// self-checking bench: host and device joined over the link
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR_L = 40;
  localparam int POR_S = 20;
  logic core_clk, srst, start, compressed, encrypted, src_valid, src_ready_q;
  logic busy_q, done_q, power_on_delay_select, io_pullup_off, tap_ir_update;
  logic io_enable_q, weak_pullup_en_q, command_mode_q, user_mode_q, user_reg_reset_q;
  logic [7:0] src_data, cfg_rd_data_q;
  logic [9:0] tap_ir;
  logic [4:0] cfg_rd_idx;
  cms_pkg::cms_scheme_t scheme;
  int err_total, samples_checked;
  logic [7:0] strm [$];
  logic [7:0] exp_b [16];
  logic [7:0] cnt [5] = '{8'h03, 8'h05, 8'h00, 8'h04, 8'h04};

  // the two ends and the checker on the link
  cms_link_if link ();
  cms_host cms_host_inst (.core_clk, .srst, .link(link), .start, .scheme, .compressed,
    .encrypted, .src_data, .src_valid, .src_ready_q, .busy_q, .done_q);
  cms_device #(.POR_LONG(POR_L), .POR_SHORT(POR_S)) cms_device_inst (.core_clk, .srst,
    .link(link), .power_on_delay_select, .io_pullup_off, .tap_ir, .tap_ir_update,
    .io_enable_q, .weak_pullup_en_q, .command_mode_q, .user_mode_q, .user_reg_reset_q,
    .cfg_rd_idx, .cfg_rd_data_q);
  cms_props cms_props_inst (.core_clk, .srst, .reconfig_request_n(link.reconfig_request_n),
    .data(link.data), .valid(link.valid), .addr(link.addr), .wr_n(link.wr_n),
    .chain_enable_out_n(link.chain_enable_out_n), .status_n(link.status_n),
    .conf_done(link.conf_done), .ready(link.ready));

  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // inputs move just after the edge to stay clear of sampling
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic hang();
    err_total++;
    final_report();
  endtask : hang

  // power-on delay for both strap settings
  task automatic t_por();
    int n;
    for (int sel = 0; sel < 2; sel++) begin
      power_on_delay_select = sel[0];
      io_pullup_off = sel[0];
      srst = 1'b1;
      repeat (10) tick();
      srst = 1'b0;
      n = 0;
      while (link.status_n !== 1'b1) begin
        if (n > 200) hang();
        tick();
        n++;
        if (n == 3) begin
          chk(weak_pullup_en_q, !io_pullup_off);
          power_on_delay_select = !sel[0]; // strap moved mid-delay must be ignored
        end
      end
      chk(n >= (sel ? POR_S : POR_L), 1);
      chk(n <= (sel ? POR_S : POR_L) + 4, 1);
      chk({io_enable_q, user_mode_q, link.conf_done}, 3'h0);
    end
  endtask : t_por

  // full load: bit 0 of s compresses, bit 1 encrypts
  task automatic t_load(input int s);
    logic [7:0] ks;
    int i, n, m;
    logic r;
    strm.delete();
    ks = 8'hA5;
    n = 0;
    if (s[0]) begin
      foreach (cnt[k]) begin
        strm.push_back(cnt[k]);
        strm.push_back(8'hC1 + k[7:0]);
        repeat (cnt[k]) begin
          exp_b[n] = 8'hC1 + k[7:0];
          n++;
        end
      end
    end else begin
      for (i = 0; i < 16; i++) begin
        exp_b[i] = 8'h3C ^ (8'h11 * i[7:0]);
        strm.push_back(exp_b[i]);
      end
    end
    // keystream walked here by hand, one step per raw byte
    if (s[1]) begin
      foreach (strm[j]) begin
        strm[j] = strm[j] ^ ks;
        ks = {ks[6:0], ks[7] ^ ks[5] ^ ks[4] ^ ks[3]};
      end
    end
    scheme = cms_pkg::cms_scheme_t'(s[2:0]);
    compressed = s[0];
    encrypted = s[1];
    start = 1'b1;
    tick();
    start = 1'b0;
    i = 0;
    n = 0;
    while (i < strm.size()) begin
      n++;
      if (n > 5000) hang();
      src_valid = 1'b1;
      src_data = strm[i];
      r = src_ready_q;
      tick();
      if (r) i++;
    end
    src_valid = 1'b0;
    chk({io_enable_q, user_mode_q}, 2'h0);
    n = 0;
    m = 0;
    while (user_mode_q !== 1'b1) begin
      n++;
      if (n > 3000) hang();
      if (link.conf_done === 1'b1) begin
        m++;
        chk({user_reg_reset_q, command_mode_q}, 2'h3);
      end
      tick();
    end
    chk(m >= cms_pkg::INIT_CYC && m <= cms_pkg::INIT_CYC + 1, 1);
    chk({io_enable_q, user_reg_reset_q, command_mode_q, link.conf_done,
      link.chain_enable_out_n}, 5'h12);
    for (i = 0; i < 16; i++) begin
      cfg_rd_idx = i[4:0];
      tick();
      chk(cfg_rd_data_q, exp_b[i]);
    end
    chk({busy_q, done_q}, 2'h1);
  endtask : t_load

  // straps frozen in user mode, then reconfig from the test port
  task automatic t_tap();
    io_pullup_off = !io_pullup_off;
    tap_ir = 10'h006;
    tap_ir_update = 1'b1;
    tick();
    tap_ir_update = 1'b0;
    repeat (4) tick();
    chk({user_mode_q, weak_pullup_en_q}, 2'h2);
    tap_ir = cms_pkg::IR_RECONFIG;
    tap_ir_update = 1'b1;
    tick();
    tap_ir_update = 1'b0;
    repeat (4) tick();
    chk({user_mode_q, io_enable_q, link.conf_done, weak_pullup_en_q}, 4'h1);
  endtask : t_tap

  // main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    srst = 1'b1;
    start = 1'b0;
    scheme = cms_pkg::fast_passive_parallel_scheme;
    {compressed, encrypted, src_valid, tap_ir_update} = 4'h0;
    {power_on_delay_select, io_pullup_off} = 2'h0;
    src_data = 8'h00;
    tap_ir = 10'h000;
    cfg_rd_idx = 5'h00;
    t_por();
    for (int s = 0; s < 5; s++) t_load(s);
    t_tap();
    t_load(3);
    final_report();
  end
endmodule : tb_top
